// ==== core/iosc_map.svh ====
`ifndef IOSC_MAP_SVH
`define IOSC_MAP_SVH

// clock and time units
`define IOSC_CLK_PERIOD_NS 100
`define IOSC_MS_NS 1000000
`define IOSC_SP_UNIT_MS 10

// line count
`define IOSC_NUM_LINES 13

// setting reset values
`define IOSC_MASK_RST 16'h0000
`define IOSC_CPS_RST 8'h01
`define IOSC_RATE_RST 16'h0000
`define IOSC_MODE_RST 8'h00
`define IOSC_OPT_RST 16'h0002

// sleep mode codes
`define IOSC_SM_NONE 8'h00
`define IOSC_SM_PIN 8'h01
`define IOSC_SM_ASYNC_CYC 8'h04
`define IOSC_SM_PIN_CYC 8'h05
`define IOSC_SM_SUPPORT 8'h07
`define IOSC_SM_SYNC_CYC 8'h08

// sleep option bit positions
`define IOSC_SO_PREF_COORD 0
`define IOSC_SO_NON_COORD 1
`define IOSC_SO_STATUS_MSG 2
`define IOSC_SO_NO_EARLY 3
`define IOSC_SO_TYPE_EQ 4
`define IOSC_SO_NO_LONE 5
`define IOSC_SO_FULL_WAKE 8

`endif

// ==== core/iosc_pkg.sv ====
`default_nettype none
package iosc_pkg;

	// which setting a host command addresses
	typedef enum logic [2:0] {
		IOSC_SEL_MASK,
		IOSC_SEL_CPS,
		IOSC_SEL_RATE,
		IOSC_SEL_MODE,
		IOSC_SEL_OPT,
		IOSC_SEL_FORCE
	} iosc_sel_e;

	// why a sample was sent
	typedef enum logic [1:0] {
		IOSC_CAUSE_NONE,
		IOSC_CAUSE_CHANGE,
		IOSC_CAUSE_PERIODIC,
		IOSC_CAUSE_FORCE
	} iosc_cause_e;

	// sleep state
	typedef enum logic {
		IOSC_AWAKE,
		IOSC_ASLEEP
	} iosc_state_e;

endpackage
`default_nettype wire

// ==== core/iosc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface iosc_if
	import iosc_pkg::*;
#(
	parameter int NUM_LINES = 13
);
	logic [NUM_LINES-1:0] lines;
	logic [NUM_LINES-1:0] digEn;
	logic anyIo;
	logic [15:0] mask;
	logic [15:0] rate;
	logic [7:0] cps;
	logic awake;
	logic wakeStart;
	logic msTick;
	logic forceReq;
	logic fire;
	iosc_cause_e cause;

	modport top (output lines, digEn, anyIo, mask, rate, cps, awake,
		wakeStart, msTick, forceReq, input fire, cause);
	modport smp (input lines, digEn, anyIo, mask, rate, cps, awake,
		wakeStart, msTick, forceReq, output fire, cause);
endinterface
`default_nettype wire

// ==== core/iosc_sampler.sv ====
`timescale 1ns/1ps
`default_nettype none
module iosc_sampler
	import iosc_pkg::*;
#(
	parameter int NUM_LINES = 13
) (
	input wire logic ref_clk, // module clock
	input wire logic rstSyncN, // synchronised reset, low active
	input wire logic clkEn, // freezes state while low
	iosc_if.smp smp // settings in, sample request out
);
	logic [NUM_LINES-1:0] prevLines_r;
	logic [NUM_LINES-1:0] changed;
	logic [7:0] cycCnt_r;
	logic cycSel_r;
	logic [15:0] msCnt_r;
	logic periodRun;
	logic periodHit;

	// enabled digital lines that moved since last cycle
	assign changed = (smp.lines ^ prevLines_r) & smp.mask[NUM_LINES-1:0]
		& smp.digEn;
	assign periodRun = (smp.rate != 16'h0000) && smp.anyIo && smp.awake
		&& cycSel_r;
	assign periodHit = periodRun && smp.msTick
		&& (msCnt_r + 16'h0001 >= smp.rate);

	// previous line state for edge detection
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			prevLines_r <= '0;
		end else if (clkEn) begin
			prevLines_r <= smp.lines;
		end
	end

	// pick every nth wake cycle
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			cycCnt_r <= 8'h00;
			cycSel_r <= 1'b1;
		end else if (clkEn && smp.wakeStart) begin
			if (cycCnt_r + 8'h01 >= smp.cps) begin
				cycCnt_r <= 8'h00;
				cycSel_r <= 1'b1;
			end else begin
				cycCnt_r <= cycCnt_r + 8'h01;
				cycSel_r <= 1'b0;
			end
		end
	end

	// periodic interval in milliseconds
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			msCnt_r <= 16'h0000;
		end else if (clkEn) begin
			if (!periodRun || periodHit) begin
				msCnt_r <= 16'h0000;
			end else if (smp.msTick) begin
				msCnt_r <= msCnt_r + 16'h0001;
			end
		end
	end

	// sample request, force before change before timer
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			smp.fire <= 1'b0;
			smp.cause <= IOSC_CAUSE_NONE;
		end else if (clkEn) begin
			smp.fire <= smp.forceReq || (|changed) || periodHit;
			if (smp.forceReq) begin
				smp.cause <= IOSC_CAUSE_FORCE;
			end else if (|changed) begin
				smp.cause <= IOSC_CAUSE_CHANGE;
			end else if (periodHit) begin
				smp.cause <= IOSC_CAUSE_PERIODIC;
			end else begin
				smp.cause <= IOSC_CAUSE_NONE;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstSyncN);

	a_change_fires: assert property (
		clkEn && (|changed) |=> smp.fire && smp.cause != IOSC_CAUSE_PERIODIC)
		else $error("enabled line change did not raise a sample");
	a_period_gated: assert property (
		smp.fire && smp.cause == IOSC_CAUSE_PERIODIC
		|-> $past(smp.rate) != 16'h0000 && $past(smp.anyIo))
		else $error("periodic sample without rate or enabled line");
	a_skip_cycle: assert property (
		clkEn && smp.wakeStart && smp.cps == 8'h02 && cycSel_r
		&& cycCnt_r == 8'h00 |=> !cycSel_r)
		else $error("wake cycle after a sampled one was not skipped");
	c_periodic: cover property (smp.fire
		&& smp.cause == IOSC_CAUSE_PERIODIC);
endmodule
`default_nettype wire

// ==== core/iosc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "iosc_map.svh"
module iosc_top
	import iosc_pkg::*;
#(
	parameter int NUM_LINES = `IOSC_NUM_LINES,
	parameter int MS_CYCLES = `IOSC_MS_NS / `IOSC_CLK_PERIOD_NS
) (
	input wire logic ref_clk, // 10 MHz clock
	input wire logic rst_n, // async reset, low active
	input wire logic clkEn, // freezes state while low
	input wire logic cmdValid, // host command strobe
	input wire logic cmdWrite, // 1 write, 0 read
	input wire iosc_sel_e cmdSel, // addressed setting
	input wire logic [15:0] cmdData, // write value
	output logic rspValid, // answer strobe
	output logic [15:0] rspData, // read or sampled value
	output logic rspReject, // write refused, or any command to an unknown setting
	input wire logic [NUM_LINES-1:0] digitalLines, // line pins
	input wire logic [NUM_LINES-1:0] lineDigitalEn, // line is digital
	input wire logic [NUM_LINES-1:0] lineAnalogEn, // line is analog
	input wire logic dozeRequestPin, // sleep request pin
	input wire logic hostIdle, // no pending work
	input wire logic [23:0] sleepPeriodSetting, // sleep, 10 ms units
	input wire logic [23:0] wakeTimeSetting, // wake time, ms
	output logic asleep, // device sleeping
	output logic syncSleep, // synchronous mode active
	output logic optPreferredCoord, // sync option bit 0
	output logic optNonCoord, // sync option bit 1
	output logic optStatusMsg, // sync option bit 2
	output logic optNoEarlyWake, // sync option bit 3
	output logic optTypeEquality, // sync option bit 4
	output logic optNoLoneRepeat, // sync option bit 5
	output logic optFullWake, // async option bit 8
	output logic sampleValid, // sample strobe
	output iosc_cause_e sampleCause, // sample reason
	output logic [NUM_LINES-1:0] sampleDigital, // enabled line levels
	output logic [NUM_LINES-1:0] sampleAnalogEn // analog lines to read
);
	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	logic [1:0] rstPipe_r;
	logic rstSyncN;
	logic [NUM_LINES-1:0] lineSync1_r, lineSync2_r;
	logic pinSync1_r, pinSync2_r;
	logic [15:0] msCnt_r;
	logic msTick_r;
	logic [15:0] mask_r, rate_r, opt_r;
	logic [7:0] cps_r, mode_r;
	logic forceReq_r;
	logic [15:0] curVal;
	logic wrOk;
	iosc_state_e state_r, stateNxt;
	logic [31:0] timer_r, timerNxt;
	logic wakeStart_r;
	logic cyclic, earlyEnd;
	logic [31:0] wakeMs, sleepMs;

	iosc_if #(.NUM_LINES(NUM_LINES)) link ();

	// supported sleep mode codes
	function automatic logic modeValid(input logic [15:0] v);
		return v == {8'h00, `IOSC_SM_NONE} || v == {8'h00, `IOSC_SM_PIN}
			|| v == {8'h00, `IOSC_SM_ASYNC_CYC}
			|| v == {8'h00, `IOSC_SM_PIN_CYC}
			|| v == {8'h00, `IOSC_SM_SUPPORT}
			|| v == {8'h00, `IOSC_SM_SYNC_CYC};
	endfunction

	// synchronous family of modes
	function automatic logic isSync(input logic [7:0] m);
		return m == `IOSC_SM_SUPPORT || m == `IOSC_SM_SYNC_CYC;
	endfunction

	// asynchronous family of modes
	function automatic logic isAsync(input logic [7:0] m);
		return m == `IOSC_SM_PIN || m == `IOSC_SM_ASYNC_CYC
			|| m == `IOSC_SM_PIN_CYC;
	endfunction

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe_r <= 2'b00;
		end else begin
			rstPipe_r <= {rstPipe_r[0], 1'b1};
		end
	end
	assign rstSyncN = rstPipe_r[1];

	// pin synchronisers
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			lineSync1_r <= '0;
			lineSync2_r <= '0;
			pinSync1_r <= 1'b0;
			pinSync2_r <= 1'b0;
		end else if (clkEn) begin
			lineSync1_r <= digitalLines;
			lineSync2_r <= lineSync1_r;
			pinSync1_r <= dozeRequestPin;
			pinSync2_r <= pinSync1_r;
		end
	end

	// one millisecond tick
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			msCnt_r <= 16'h0000;
			msTick_r <= 1'b0;
		end else if (clkEn) begin
			msTick_r <= (msCnt_r == MS_LAST);
			if (msCnt_r == MS_LAST) begin
				msCnt_r <= 16'h0000;
			end else begin
				msCnt_r <= msCnt_r + 16'h0001;
			end
		end
	end

	// readback and write acceptance
	always_comb begin
		curVal = 16'h0000;
		wrOk = 1'b1;
		unique case (cmdSel)
		IOSC_SEL_MASK: begin
			curVal = mask_r;
		end
		IOSC_SEL_CPS: begin
			curVal = {8'h00, cps_r};
			wrOk = cmdData[15:8] == 8'h00 && cmdData[7:0] != 8'h00;
		end
		IOSC_SEL_RATE: begin
			curVal = rate_r;
		end
		IOSC_SEL_MODE: begin
			curVal = {8'h00, mode_r};
			wrOk = modeValid(cmdData);
		end
		IOSC_SEL_OPT: begin
			curVal = opt_r;
			wrOk = !(cmdData[`IOSC_SO_PREF_COORD]
				&& cmdData[`IOSC_SO_NON_COORD]);
		end
		IOSC_SEL_FORCE: begin
			curVal = 16'(lineSync2_r & lineDigitalEn);
		end
		default: begin
			wrOk = 1'b0;
		end
		endcase
	end

	// settings written by host
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			mask_r <= `IOSC_MASK_RST;
			cps_r <= `IOSC_CPS_RST;
			rate_r <= `IOSC_RATE_RST;
			mode_r <= `IOSC_MODE_RST;
			opt_r <= `IOSC_OPT_RST;
		end else if (clkEn && cmdValid && cmdWrite && wrOk) begin
			unique case (cmdSel)
			IOSC_SEL_MASK: mask_r <= cmdData;
			IOSC_SEL_CPS: cps_r <= cmdData[7:0];
			IOSC_SEL_RATE: rate_r <= cmdData;
			IOSC_SEL_MODE: mode_r <= cmdData[7:0];
			IOSC_SEL_OPT: opt_r <= cmdData;
			default: ;
			endcase
		end
	end

	// command answer and force request
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			rspValid <= 1'b0;
			rspData <= 16'h0000;
			rspReject <= 1'b0;
			forceReq_r <= 1'b0;
		end else if (clkEn) begin
			rspValid <= cmdValid;
			rspReject <= cmdValid && !wrOk
				&& (cmdWrite || cmdSel > IOSC_SEL_FORCE);
			rspData <= (cmdValid && cmdWrite && wrOk
				&& cmdSel != IOSC_SEL_FORCE) ? cmdData : curVal;
			forceReq_r <= cmdValid && cmdSel == IOSC_SEL_FORCE;
		end
	end

	// sleep timing limits
	assign wakeMs = {8'h00, wakeTimeSetting};
	assign sleepMs = 32'({8'h00, sleepPeriodSetting}
		* 32'(`IOSC_SP_UNIT_MS));
	assign cyclic = mode_r == `IOSC_SM_ASYNC_CYC
		|| mode_r == `IOSC_SM_SYNC_CYC
		|| (mode_r == `IOSC_SM_PIN_CYC && pinSync2_r);
	assign earlyEnd = !opt_r[`IOSC_SO_FULL_WAKE] && hostIdle
		&& isAsync(mode_r);

	// sleep state decision
	always_comb begin
		stateNxt = state_r;
		timerNxt = timer_r;
		if (mode_r == `IOSC_SM_PIN) begin
			stateNxt = pinSync2_r ? IOSC_ASLEEP : IOSC_AWAKE;
			timerNxt = 32'h0000_0000;
		end else if (!cyclic) begin
			stateNxt = IOSC_AWAKE;
			timerNxt = 32'h0000_0000;
		end else if (state_r == IOSC_AWAKE && earlyEnd) begin
			stateNxt = IOSC_ASLEEP;
			timerNxt = 32'h0000_0000;
		end else if (msTick_r) begin
			unique case (state_r)
			IOSC_AWAKE: begin
				if (timer_r + 32'h0000_0001 >= wakeMs) begin
					stateNxt = IOSC_ASLEEP;
					timerNxt = 32'h0000_0000;
				end else begin
					timerNxt = timer_r + 32'h0000_0001;
				end
			end
			IOSC_ASLEEP: begin
				if (timer_r + 32'h0000_0001 >= sleepMs) begin
					stateNxt = IOSC_AWAKE;
					timerNxt = 32'h0000_0000;
				end else begin
					timerNxt = timer_r + 32'h0000_0001;
				end
			end
			endcase
		end
	end

	// sleep state registers
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_r <= IOSC_AWAKE;
			timer_r <= 32'h0000_0000;
			asleep <= 1'b0;
			wakeStart_r <= 1'b0;
		end else if (clkEn) begin
			state_r <= stateNxt;
			timer_r <= timerNxt;
			asleep <= stateNxt == IOSC_ASLEEP;
			wakeStart_r <= state_r == IOSC_ASLEEP
				&& stateNxt == IOSC_AWAKE;
		end
	end

	// option flags decoded per mode family
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			syncSleep <= 1'b0;
			optPreferredCoord <= 1'b0;
			optNonCoord <= 1'b0;
			optStatusMsg <= 1'b0;
			optNoEarlyWake <= 1'b0;
			optTypeEquality <= 1'b0;
			optNoLoneRepeat <= 1'b0;
			optFullWake <= 1'b0;
		end else if (clkEn) begin
			syncSleep <= isSync(mode_r);
			optPreferredCoord <= isSync(mode_r)
				&& opt_r[`IOSC_SO_PREF_COORD];
			optNonCoord <= isSync(mode_r) && opt_r[`IOSC_SO_NON_COORD];
			optStatusMsg <= isSync(mode_r) && opt_r[`IOSC_SO_STATUS_MSG];
			optNoEarlyWake <= isSync(mode_r) && opt_r[`IOSC_SO_NO_EARLY];
			optTypeEquality <= isSync(mode_r) && opt_r[`IOSC_SO_TYPE_EQ];
			optNoLoneRepeat <= isSync(mode_r) && opt_r[`IOSC_SO_NO_LONE];
			optFullWake <= isAsync(mode_r)
				&& opt_r[`IOSC_SO_FULL_WAKE];
		end
	end

	// settings and events toward the sampler
	assign link.lines = lineSync2_r;
	assign link.digEn = lineDigitalEn;
	assign link.anyIo = (|lineDigitalEn) || (|lineAnalogEn);
	assign link.mask = mask_r;
	assign link.rate = rate_r;
	assign link.cps = cps_r;
	assign link.awake = state_r == IOSC_AWAKE;
	assign link.wakeStart = wakeStart_r;
	assign link.msTick = msTick_r;
	assign link.forceReq = forceReq_r;

	iosc_sampler #(.NUM_LINES(NUM_LINES)) sampler (
		.ref_clk(ref_clk),
		.rstSyncN(rstSyncN),
		.clkEn(clkEn),
		.smp(link)
	);

	// sample outputs
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			sampleValid <= 1'b0;
			sampleCause <= IOSC_CAUSE_NONE;
			sampleDigital <= '0;
			sampleAnalogEn <= '0;
		end else if (clkEn) begin
			sampleValid <= link.fire;
			if (link.fire) begin
				sampleCause <= link.cause;
				sampleDigital <= lineSync2_r & lineDigitalEn;
				sampleAnalogEn <= lineAnalogEn;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstSyncN);

	a_mode_reject: assert property (
		clkEn && cmdValid && cmdWrite && cmdSel == IOSC_SEL_MODE
		&& !modeValid(cmdData) |=> mode_r == $past(mode_r) && rspReject)
		else $error("unsupported sleep mode accepted");
	a_opt_exclusive: assert property (
		!(opt_r[`IOSC_SO_PREF_COORD] && opt_r[`IOSC_SO_NON_COORD]))
		else $error("both coordinator option bits set");
	a_mode_none: assert property (
		clkEn && mode_r == `IOSC_SM_NONE |=> !asleep)
		else $error("slept in mode 0");
	a_pin_follow: assert property (
		clkEn && mode_r == `IOSC_SM_PIN |=> asleep == $past(pinSync2_r))
		else $error("pin sleep does not follow the pin");
	a_pin_wake: assert property (
		clkEn && mode_r == `IOSC_SM_PIN_CYC && !pinSync2_r |=> !asleep)
		else $error("mode 5 asleep with pin released");
	a_force_answer: assert property (
		clkEn && cmdValid && cmdSel == IOSC_SEL_FORCE
		|=> rspValid && !rspReject)
		else $error("force command not answered");
	a_cps_reject: assert property (
		clkEn && cmdValid && cmdWrite && cmdSel == IOSC_SEL_CPS
		&& cmdData == 16'h0000 |=> cps_r == $past(cps_r))
		else $error("zero cycles per sample accepted");
	a_sync_opts: assert property (
		optPreferredCoord || optNonCoord |-> syncSleep)
		else $error("sync option shown outside sync mode");
	c_cyclic_sleep: cover property (mode_r == `IOSC_SM_ASYNC_CYC
		&& $rose(asleep));
	c_force: cover property (sampleValid
		&& sampleCause == IOSC_CAUSE_FORCE);
	c_change: cover property (sampleValid
		&& sampleCause == IOSC_CAUSE_CHANGE);
endmodule
`default_nettype wire

// ==== verif/iosc_doze_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module iosc_doze_host (
	input wire logic ref_clk, // module clock
	input wire logic want, // wished pin level
	input wire logic [3:0] lag, // cycles before the pin follows
	output logic dozePin // sleep request pin, driven push-pull
);
	logic [3:0] cnt;
	// pin follows the wish after a lag, changing just after an edge
	initial begin
		dozePin = 1'b0;
		cnt = 4'h0;
		forever begin
			@(posedge ref_clk);
			#1;
			if (want == dozePin) cnt = 4'h0;
			else if (cnt >= lag) begin
				dozePin = want;
				cnt = 4'h0;
			end else cnt = cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ==== verif/io_sampling_and_sleep_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module io_sampling_and_sleep_control_tb
	import iosc_pkg::*;
;
	localparam int MS = 10;
	logic ref_clk, rst_n, clkEn, cmdValid, cmdWrite, rspValid, rspReject;
	iosc_sel_e cmdSel;
	logic [15:0] cmdData, rspData;
	logic [12:0] lines, digEn, anaEn, sDig, sAna;
	logic want, dozePin, hostIdle, asleep, syncSleep, sValid, oFull;
	logic [3:0] lag;
	logic [23:0] sp, wt;
	logic [5:0] oSync;
	iosc_cause_e sCause;
	int nErrors = 0;
	int checked = 0;
	int cyc = 0;
	logic [15:0] d;
	logic r;

	iosc_top #(.MS_CYCLES(MS)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.clkEn(clkEn), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
		.cmdSel(cmdSel), .cmdData(cmdData), .rspValid(rspValid),
		.rspData(rspData), .rspReject(rspReject), .digitalLines(lines),
		.lineDigitalEn(digEn), .lineAnalogEn(anaEn),
		.dozeRequestPin(dozePin), .hostIdle(hostIdle),
		.sleepPeriodSetting(sp), .wakeTimeSetting(wt), .asleep(asleep),
		.syncSleep(syncSleep), .optPreferredCoord(oSync[0]),
		.optNonCoord(oSync[1]), .optStatusMsg(oSync[2]),
		.optNoEarlyWake(oSync[3]), .optTypeEquality(oSync[4]),
		.optNoLoneRepeat(oSync[5]), .optFullWake(oFull),
		.sampleValid(sValid), .sampleCause(sCause), .sampleDigital(sDig),
		.sampleAnalogEn(sAna));
	iosc_doze_host u_host (.ref_clk(ref_clk), .want(want), .lag(lag),
		.dozePin(dozePin));

	// clock and run limit
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			nErrors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("errors %0d of %0d compares", nErrors, checked);
		if (nErrors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			nErrors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one command, answer taken in the cycle after it is accepted
	task automatic cmd(input int sel, input logic wr, input logic [15:0] v);
		@(posedge ref_clk) #1;
		cmdValid = 1'b1;
		cmdWrite = wr;
		cmdSel = iosc_sel_e'(sel);
		cmdData = v;
		@(posedge ref_clk) #1;
		cmdValid = 1'b0;
		chk({15'h0, rspValid}, 16'h1);
		d = rspData;
		r = rspReject;
	endtask

	task automatic waitSample(input int n);
		r = 1'b0;
		for (int i = 0; i < n && !r; i++) begin
			@(posedge ref_clk) #1;
			r = (sValid === 1'b1);
		end
	endtask

	task automatic waitSleep(input logic lvl, input int n);
		for (int i = 0; i < n && asleep !== lvl; i++) @(posedge ref_clk) #1;
		chk({15'h0, asleep}, {15'h0, lvl});
	endtask

	// asleep span then awake span of a freshly entered sleep
	task automatic spans(output int sl, output int aw);
		sl = 0;
		aw = 0;
		waitSleep(1'b0, 300);
		waitSleep(1'b1, 300);
		while (asleep === 1'b1 && sl < 500) begin
			@(posedge ref_clk) #1;
			sl++;
		end
		while (asleep === 1'b0 && aw < 500) begin
			@(posedge ref_clk) #1;
			aw++;
		end
	endtask

	// samples seen during the next whole wake span
	task automatic wakeSamples(output int n);
		n = 0;
		waitSleep(1'b1, 300);
		waitSleep(1'b0, 300);
		for (int i = 0; i < 100 && asleep === 1'b0; i++) begin
			if (sValid === 1'b1) n++;
			@(posedge ref_clk) #1;
		end
	endtask

	function automatic logic [15:0] near(input int a, input int b);
		return {15'h0, a >= b - 2 && a <= b + 2};
	endfunction

	initial begin
		logic [15:0] rv [5];
		logic [15:0] last;
		int sl, aw;
		rv = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0002};
		rst_n = 1'b0;
		clkEn = 1'b1;
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdSel = IOSC_SEL_MASK;
		cmdData = 16'h0000;
		lines = 13'h0000;
		digEn = 13'h1FFF;
		anaEn = 13'h0000;
		want = 1'b0;
		lag = 4'h2;
		hostIdle = 1'b0;
		sp = 24'h000001;
		wt = 24'h000002;
		repeat (12) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 5; i++) begin
			cmd(i, 1'b0, 16'h0000);
			chk(d, rv[i]);
		end
		cmd(6, 1'b1, 16'h0001);
		chk({15'h0, r}, 16'h1);
		// mode codes 0 to 9, legal or not
		last = 16'h0000;
		for (int m = 0; m < 10; m++) begin
			cmd(3, 1'b1, 16'(m));
			chk({15'h0, r}, {15'h0, !(m inside {0, 1, 4, 5, 7, 8})});
			if (!r) last = 16'(m);
			cmd(3, 1'b0, 16'h0000);
			chk(d, last);
			chk({15'h0, syncSleep}, {15'h0, last inside {7, 8}});
		end
		cmd(1, 1'b1, 16'h0000);
		chk({15'h0, r}, 16'h1);
		cmd(1, 1'b1, 16'h0100);
		chk({15'h0, r}, 16'h1);
		cmd(4, 1'b1, 16'h0003);
		chk({15'h0, r}, 16'h1);
		cmd(4, 1'b1, 16'h013D);
		cmd(4, 1'b0, 16'h0000);
		chk({9'h0, oFull, oSync}, 16'h003D);
		cmd(3, 1'b1, 16'h0004);
		cmd(4, 1'b0, 16'h0000);
		chk({9'h0, oFull, oSync}, 16'h0040);
		// cyclic sleep, full wake time with options bit 8 set
		hostIdle = 1'b1;
		spans(sl, aw);
		chk(near(sl, 10 * MS), 16'h1);
		chk(near(aw, 2 * MS), 16'h1);
		cmd(4, 1'b1, 16'h0002);
		spans(sl, aw);
		chk({15'h0, aw < 2 * MS - 2}, 16'h1);
		hostIdle = 1'b0;
		// pin driven sleep
		cmd(3, 1'b1, 16'h0001);
		waitSleep(1'b0, 4);
		want = 1'b1;
		waitSleep(1'b1, 12);
		want = 1'b0;
		waitSleep(1'b0, 12);
		cmd(3, 1'b1, 16'h0005);
		repeat (150) @(posedge ref_clk);
		#1 chk({15'h0, asleep}, 16'h0);
		want = 1'b1;
		waitSleep(1'b1, 60);
		want = 1'b0;
		waitSleep(1'b0, 10);
		cmd(3, 1'b1, 16'h0000);
		want = 1'b1;
		repeat (30) @(posedge ref_clk);
		#1 chk({15'h0, asleep}, 16'h0);
		want = 1'b0;
		// change detection on line 3 only, unused mask bits zero
		cmd(0, 1'b1, 16'h0008);
		lines = 13'h0010;
		waitSample(10);
		chk({15'h0, r}, 16'h0);
		lines = 13'h0018;
		waitSample(10);
		chk({15'h0, r}, 16'h1);
		chk({14'h0, sCause}, 16'(IOSC_CAUSE_CHANGE));
		chk({3'h0, sDig}, 16'h0018);
		// forced sample of the enabled lines
		digEn = 13'h0F0F;
		anaEn = 13'h00F0;
		cmd(5, 1'b0, 16'h0000);
		chk(d, 16'h0008);
		waitSample(6);
		chk({14'h0, sCause}, 16'(IOSC_CAUSE_FORCE));
		chk({3'h0, sAna}, 16'h00F0);
		// periodic sampling every two milliseconds
		cmd(2, 1'b1, 16'h0002);
		waitSample(60);
		chk({15'h0, r}, 16'h1);
		sl = 0;
		r = 1'b0;
		while (!r && sl < 60) begin
			@(posedge ref_clk) #1;
			r = (sValid === 1'b1);
			sl++;
		end
		chk(near(sl, 2 * MS), 16'h1);
		chk({14'h0, sCause}, 16'(IOSC_CAUSE_PERIODIC));
		cmd(2, 1'b1, 16'h0000);
		waitSample(50);
		chk({15'h0, r}, 16'h0);
		// every second wake cycle samples when cycles per sample is two
		cmd(1, 1'b1, 16'h0002);
		cmd(2, 1'b1, 16'h0001);
		cmd(3, 1'b1, 16'h0004);
		wakeSamples(sl);
		wakeSamples(aw);
		chk(16'(sl), 16'h0000);
		chk({15'h0, aw > 0}, 16'h0001);
		final_report();
	end
endmodule
`default_nettype wire
